// ===== hdl/acc_top.sv
// Analog comparator control: input select, result sync, events, Wishbone
`timescale 1ns/1ps
module acc_top (
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Analog comparator macro
    input  wire logic                 cmp_raw_i,
    output acc_pkg::acc_sel_t         cmp_sel_o,
    // Pin digital inputs and their buffer enables
    input  wire logic                 cmp_pos_pin_i,
    input  wire logic                 cmp_neg_pin_i,
    output logic                      pos_buf_en_o,
    output logic                      neg_buf_en_o,
    // Processor side
    input  wire logic                 vector_ack_i,
    output logic                      cmp_irq_o,
    output logic                      capture_o,
    output logic                      ev_irq_o
);
    // Register state
    logic [7:0] csr_q, csr_d;   // Control/status (flag and result kept apart)
    logic       flag_q, flag_d; // cmp_irq_flag
    logic [7:0] ccb_q, ccb_d;   // converter_control_b
    logic [7:0] did_q, did_d;   // digital_input_disable_one
    logic [7:0] cfg_q, cfg_d;   // converter_enable, global enable, channel
    logic [1:0] isr_q, isr_d;   // Sticky events: bit0 flag set, bit1 result
    logic [1:0] imr_q, imr_d;   // Event mask
    logic       ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    // Output registers
    logic       irq_q, irq_d;
    logic       cap_q, cap_d;
    logic       evi_q, evi_d;
    acc_pkg::acc_sel_t sel_q, sel_d;
    logic       pos_en_q, pos_en_d;
    logic       neg_en_q, neg_en_d;

    // Synchronised comparator result and pins
    logic res_s, res_p;
    logic pos_s, neg_s;

    // Comparator output is asynchronous to clk_i
    acc_sync u_res (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .async_i(cmp_raw_i),
        .sync_o (res_s),
        .prev_o (res_p)
    );
    acc_sync u_pos (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .async_i(cmp_pos_pin_i),
        .sync_o (pos_s),
        .prev_o ()            // No edge history needed for pins
    );
    acc_sync u_neg (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .async_i(cmp_neg_pin_i),
        .sync_o (neg_s),
        .prev_o ()            // No edge history needed for pins
    );

    // Bus decode helpers
    logic req, wr, rd_en;
    logic [1:0] mode;
    logic       event_hit;
    logic       muxsel;
    logic [7:0] csr_view;

    // Event detect and decode
    always_comb
    begin
        req  = wb_cyc_i && wb_stb_i && !ack_q;
        wr   = req && wb_we_i && wb_sel_i[0];
        rd_en = req && !wb_we_i;
        mode = csr_q[acc_pkg::ACC_MHI_BIT:acc_pkg::ACC_MLO_BIT];
        // Mode selects the edge; cmp_disable gates only the flag set, not the result-change event
        case (mode)
            acc_pkg::ACC_MODE_TOG:  event_hit = res_s ^ res_p;
            acc_pkg::ACC_MODE_FALL: event_hit = res_p & ~res_s;
            acc_pkg::ACC_MODE_RISE: event_hit = res_s & ~res_p;
            default:                event_hit = 1'b0; // Reserved
        endcase
        // Multiplexing only while converter is off
        muxsel = ccb_q[acc_pkg::ACC_MUXEN_BIT] &&
                 !cfg_q[acc_pkg::ACC_CEN_BIT];
        csr_view = csr_q;
        csr_view[acc_pkg::ACC_RES_BIT]  = res_s;
        csr_view[acc_pkg::ACC_FLAG_BIT] = flag_q;
    end

    // Register next-state logic
    always_comb
    begin
        csr_d  = csr_q;
        flag_d = flag_q;
        ccb_d  = ccb_q;
        did_d  = did_q;
        cfg_d  = cfg_q;
        isr_d  = isr_q;
        imr_d  = imr_q;
        ack_d  = req;
        dat_d  = 32'h0000_0000;
        // Software writes first, hardware sets win afterwards
        if (wr)
        begin
            case (wb_adr_i)
                acc_pkg::ACC_CSR_OFS:
                begin
                    // Result and flag are not plain storage
                    csr_d = wb_dat_i[7:0];
                    csr_d[acc_pkg::ACC_RES_BIT]  = 1'b0;
                    csr_d[acc_pkg::ACC_FLAG_BIT] = 1'b0;
                    if (wb_dat_i[acc_pkg::ACC_FLAG_BIT])
                        flag_d = 1'b0;
                end
                acc_pkg::ACC_CCB_OFS: ccb_d = wb_dat_i[7:0];
                acc_pkg::ACC_DID_OFS: did_d = wb_dat_i[7:0];
                acc_pkg::ACC_CFG_OFS: cfg_d = wb_dat_i[7:0];
                acc_pkg::ACC_ISR_OFS: isr_d = isr_q & ~wb_dat_i[1:0];
                acc_pkg::ACC_IMR_OFS: imr_d = wb_dat_i[1:0];
                default: ;
            endcase
        end
        if (vector_ack_i)
            flag_d = 1'b0;
        // Set beats clear in the same cycle
        if (event_hit && !csr_q[acc_pkg::ACC_DIS_BIT])
        begin
            flag_d   = 1'b1;
            isr_d[0] = 1'b1;
        end
        if (res_s ^ res_p)
            isr_d[1] = 1'b1;
        // Read mux; unmapped reads zero
        if (rd_en)
        begin
            case (wb_adr_i)
                acc_pkg::ACC_CSR_OFS: dat_d = {24'h000000, csr_view};
                acc_pkg::ACC_CCB_OFS: dat_d = {24'h000000, ccb_q};
                acc_pkg::ACC_DID_OFS: dat_d = {24'h000000, did_q};
                acc_pkg::ACC_CFG_OFS: dat_d = {24'h000000, cfg_q};
                acc_pkg::ACC_ISR_OFS: dat_d = {30'h00000000, isr_q};
                acc_pkg::ACC_IMR_OFS: dat_d = {30'h00000000, imr_q};
                acc_pkg::ACC_PIN_OFS:
                    // Disabled buffers read zero
                    dat_d = {30'h00000000,
                             neg_s & ~did_q[acc_pkg::ACC_NOFF_BIT],
                             pos_s & ~did_q[acc_pkg::ACC_POFF_BIT]};
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    // Output next-state logic
    always_comb
    begin
        // Request gated by flag, enable and global enable
        irq_d = flag_d && csr_d[acc_pkg::ACC_IEN_BIT] &&
                cfg_d[acc_pkg::ACC_GIE_BIT];
        // Capture path only when routed
        cap_d = csr_q[acc_pkg::ACC_CAP_BIT] && res_s;
        evi_d = |(isr_d & imr_d);
        sel_d.power_on    = !csr_q[acc_pkg::ACC_DIS_BIT];
        sel_d.pos_bandgap = csr_q[acc_pkg::ACC_BG_BIT];
        sel_d.neg_is_chan = muxsel;
        sel_d.neg_chan    = muxsel ? cfg_q[acc_pkg::ACC_CHS_LSB +: 3]
                                   : 3'h0;
        pos_en_d = !did_q[acc_pkg::ACC_POFF_BIT];
        neg_en_d = !did_q[acc_pkg::ACC_NOFF_BIT];
    end

    // State registers, synchronous reset
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            csr_q    <= acc_pkg::ACC_CSR_RST;
            flag_q   <= 1'b0;
            ccb_q    <= acc_pkg::ACC_REG_RST;
            did_q    <= acc_pkg::ACC_REG_RST;
            cfg_q    <= acc_pkg::ACC_REG_RST;
            isr_q    <= acc_pkg::ACC_EV_RST;
            imr_q    <= acc_pkg::ACC_EV_RST;
            ack_q    <= 1'b0;
            dat_q    <= 32'h0000_0000;
            irq_q    <= 1'b0;
            cap_q    <= 1'b0;
            evi_q    <= 1'b0;
            sel_q    <= '{power_on: 1'b1, pos_bandgap: 1'b0,
                          neg_is_chan: 1'b0, neg_chan: 3'h0};
            pos_en_q <= 1'b1;
            neg_en_q <= 1'b1;
        end
        else
        begin
            csr_q    <= csr_d;
            flag_q   <= flag_d;
            ccb_q    <= ccb_d;
            did_q    <= did_d;
            cfg_q    <= cfg_d;
            isr_q    <= isr_d;
            imr_q    <= imr_d;
            ack_q    <= ack_d;
            dat_q    <= dat_d;
            irq_q    <= irq_d;
            cap_q    <= cap_d;
            evi_q    <= evi_d;
            sel_q    <= sel_d;
            pos_en_q <= pos_en_d;
            neg_en_q <= neg_en_d;
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = dat_q;
    assign cmp_irq_o    = irq_q;
    assign capture_o    = cap_q;
    assign ev_irq_o     = evi_q;
    assign cmp_sel_o    = sel_q;
    assign pos_buf_en_o = pos_en_q;
    assign neg_buf_en_o = neg_en_q;

    // Checks; all on the system clock, quiet while reset is held
    AST_RISE_FLAG: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == acc_pkg::ACC_MODE_RISE && res_s && !res_p &&
         !csr_q[acc_pkg::ACC_DIS_BIT]) |=> flag_q)
        else $error("rising event did not set flag");
    AST_RSV_MODE: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == acc_pkg::ACC_MODE_RSV && !flag_q && !vector_ack_i)
        |=> !flag_q)
        else $error("reserved mode set flag");
    AST_VEC_CLR: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (vector_ack_i && !event_hit) |=> !flag_q)
        else $error("vector did not clear flag");
    // A vector in the same cycle may clear the flag legitimately
    AST_W1C: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (wr && wb_adr_i == acc_pkg::ACC_CSR_OFS && !vector_ack_i &&
         !wb_dat_i[acc_pkg::ACC_FLAG_BIT] && flag_q)
        |=> flag_q)
        else $error("zero write cleared flag");
    AST_IRQ: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cmp_irq_o |-> flag_q && csr_q[acc_pkg::ACC_IEN_BIT] &&
                      cfg_q[acc_pkg::ACC_GIE_BIT])
        else $error("request without flag or enable");
    AST_MUX: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_q[acc_pkg::ACC_CEN_BIT] ##1 cfg_q[acc_pkg::ACC_CEN_BIT]
        |-> !cmp_sel_o.neg_is_chan)
        else $error("mux used while converter on");
    AST_CAP: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !csr_q[acc_pkg::ACC_CAP_BIT] |=> !capture_o)
        else $error("capture routed while off");
    AST_SYNC: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        res_s |-> $past(cmp_raw_i, 2))
        else $error("result not two stages late");
    AST_PINRD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (rd_en && wb_adr_i == acc_pkg::ACC_PIN_OFS &&
         did_q[acc_pkg::ACC_POFF_BIT]) |=> !wb_dat_o[0])
        else $error("disabled pin read nonzero");
    // Analog selection must follow the registers one cycle later
    AST_CHAN: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (ccb_q[acc_pkg::ACC_MUXEN_BIT] && !cfg_q[acc_pkg::ACC_CEN_BIT])
        |=> cmp_sel_o.neg_is_chan &&
            cmp_sel_o.neg_chan == $past(cfg_q[acc_pkg::ACC_CHS_LSB +: 3]))
        else $error("channel select not applied");
    AST_BGSEL: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cmp_sel_o.pos_bandgap == $past(csr_q[acc_pkg::ACC_BG_BIT]))
        else $error("bandgap select not applied");
    AST_DISPWR: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cmp_sel_o.power_on == !$past(csr_q[acc_pkg::ACC_DIS_BIT]))
        else $error("power state does not follow disable bit");
    AST_BUFEN: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        pos_buf_en_o == !$past(did_q[acc_pkg::ACC_POFF_BIT]) &&
        neg_buf_en_o == !$past(did_q[acc_pkg::ACC_NOFF_BIT]))
        else $error("input buffer enable does not follow register");
endmodule

// ===== pkg/acc_pkg.sv
// Package: register map, field positions and types of the comparator control
package acc_pkg;
    // Register byte offsets (classic Wishbone, 32-bit words)
    localparam logic [7:0] ACC_CSR_OFS   = 8'h30; // comparator_control_status
    localparam logic [7:0] ACC_CCB_OFS   = 8'h34; // converter_control_b
    localparam logic [7:0] ACC_DID_OFS   = 8'h38; // digital_input_disable_one
    localparam logic [7:0] ACC_CFG_OFS   = 8'h3C; // converter/processor control
    localparam logic [7:0] ACC_ISR_OFS   = 8'h40; // sticky event status
    localparam logic [7:0] ACC_IMR_OFS   = 8'h44; // event mask
    localparam logic [7:0] ACC_PIN_OFS   = 8'h48; // pin input read

    // Field positions: control/status, converter_control_b, digital_input_disable_one, config
    localparam int ACC_DIS_BIT   = 7; // cmp_disable
    localparam int ACC_BG_BIT    = 6; // bandgap_select
    localparam int ACC_RES_BIT   = 5; // cmp_result
    localparam int ACC_FLAG_BIT  = 4; // cmp_irq_flag
    localparam int ACC_IEN_BIT   = 3; // cmp_irq_enable
    localparam int ACC_CAP_BIT   = 2; // capture_route_enable
    localparam int ACC_MHI_BIT   = 1; // irq_mode_hi
    localparam int ACC_MLO_BIT   = 0; // irq_mode_lo
    localparam int ACC_MUXEN_BIT = 6; // neg_mux_enable in converter_control_b
    localparam int ACC_NOFF_BIT  = 1; // neg_pin_input_off
    localparam int ACC_POFF_BIT  = 0; // pos_pin_input_off
    localparam int ACC_CEN_BIT   = 7; // converter_enable in config register
    localparam int ACC_GIE_BIT   = 3; // global enable in config register
    localparam int ACC_CHS_LSB   = 0; // channel_select, 3 bits

    // Reset values
    localparam logic [7:0] ACC_CSR_RST = 8'h00;
    localparam logic [7:0] ACC_REG_RST = 8'h00;
    localparam logic [1:0] ACC_EV_RST  = 2'h0;

    // Interrupt mode field encodings
    localparam logic [1:0] ACC_MODE_TOG  = 2'h0;
    localparam logic [1:0] ACC_MODE_RSV  = 2'h1;
    localparam logic [1:0] ACC_MODE_FALL = 2'h2;
    localparam logic [1:0] ACC_MODE_RISE = 2'h3;

    // Analog-side selection handed to the comparator macro
    typedef struct packed {
        logic       power_on;   // Comparator powered
        logic       pos_bandgap; // Positive input is bandgap
        logic       neg_is_chan; // Negative input from converter mux
        logic [2:0] neg_chan;   // Converter channel number
    } acc_sel_t;

    // Wishbone slave response
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } acc_wb_rsp_t;
endpackage

// ===== hdl/acc_sync.sv
// Two-flop synchroniser with previous-value stage for edge detection
`timescale 1ns/1ps
module acc_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic async_i,
    output logic      sync_o,
    output logic      prev_o
);
    logic meta_q; // First stage, read only by sync_o stage
    logic sync_q; // Second stage
    logic prev_q; // One cycle older copy

    // Plain register chain; reset to a constant low
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sync_o = sync_q;
    assign prev_o = prev_q;
endmodule

// ===== tb/acc_top_tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module acc_top_tb_top;
    logic              clk_i;           // 25 MHz system clock
    logic              nrst_i;          // Sync reset, low active
    logic              wb_cyc_i;        // Bus cycle
    logic              wb_stb_i;        // Bus strobe
    logic              wb_we_i;         // Write when high
    logic [7:0]        wb_adr_i;        // Byte address
    logic [3:0]        wb_sel_i;        // Byte lanes
    logic [31:0]       wb_dat_i;        // Write data
    logic [31:0]       wb_dat_o;        // Read data
    logic              wb_ack_o;        // Slave answer
    logic              cmp_raw_i;       // Raw comparator level
    logic              cmp_pos_pin_i;   // Positive pin digital level
    logic              cmp_neg_pin_i;   // Negative pin digital level
    logic              vector_ack_i;    // Processor took the vector
    acc_pkg::acc_sel_t cmp_sel_o;       // Analog selection
    logic              pos_buf_en_o;    // Positive buffer on
    logic              neg_buf_en_o;    // Negative buffer on
    logic              cmp_irq_o;       // Comparator request
    logic              capture_o;       // Timer capture feed
    logic              ev_irq_o;        // Status/mask request
    int                failures;        // Mismatch count
    int                samples_checked; // Comparison count
    logic [31:0]       rd;              // Last read data

    acc_top acc_top_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cmp_raw_i(cmp_raw_i), .cmp_sel_o(cmp_sel_o),
        .cmp_pos_pin_i(cmp_pos_pin_i), .cmp_neg_pin_i(cmp_neg_pin_i),
        .pos_buf_en_o(pos_buf_en_o), .neg_buf_en_o(neg_buf_en_o),
        .vector_ack_i(vector_ack_i), .cmp_irq_o(cmp_irq_o),
        .capture_o(capture_o), .ev_irq_o(ev_irq_o)
    );

    // Free-running clock, 40 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Report counts and verdict, then stop
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One comparison, reported at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Let a number of edges pass
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1); // Only the watchdog ends a lost ack
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Full-lane write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    // Read and compare the masked bits
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        wb(1'b0, a, 8'h00, 4'hF);
        chk(rd & m, e);
    endtask

    // Runaway guard, well above the expected run
    initial
    begin
        #(40 * 20000);
        failures++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        failures = 0;
        samples_checked = 0;
        nrst_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        cmp_raw_i = 1'b0;
        cmp_pos_pin_i = 1'b0;
        cmp_neg_pin_i = 1'b0;
        vector_ack_i = 1'b0;
        tick(4);
        nrst_i <= 1'b1;
        // Reset state, unmapped read
        rchk(acc_pkg::ACC_CSR_OFS, 32'hFFFFFFFF, 32'h0);
        chk({26'h0, cmp_sel_o}, 32'h20);
        chk({30'h0, pos_buf_en_o, neg_buf_en_o}, 32'h3);
        rchk(8'h4C, 32'hFFFFFFFF, 32'h0);
        // Every channel through the converter mux
        wr(acc_pkg::ACC_CCB_OFS, 8'h40);
        for (int n = 0; n < 8; n++)
        begin
            wr(acc_pkg::ACC_CFG_OFS, 8'(n));
            tick(2);
            chk({26'h0, cmp_sel_o}, 32'h28 | n);
        end
        // Converter on, then mux off: negative pin
        wr(acc_pkg::ACC_CFG_OFS, 8'h85);
        tick(2);
        chk({26'h0, cmp_sel_o}, 32'h20);
        wr(acc_pkg::ACC_CFG_OFS, 8'h05);
        wr(acc_pkg::ACC_CCB_OFS, 8'h00);
        tick(2);
        chk({26'h0, cmp_sel_o}, 32'h20);
        wr(acc_pkg::ACC_CSR_OFS, 8'h40);
        tick(2);
        chk({26'h0, cmp_sel_o}, 32'h30);
        // Lane 0 off: write must not land
        wb(1'b1, acc_pkg::ACC_CSR_OFS, 8'h80, 4'hE);
        tick(2);
        chk({26'h0, cmp_sel_o}, 32'h30);
        wr(acc_pkg::ACC_CSR_OFS, 8'h80);
        tick(2);
        chk({26'h0, cmp_sel_o}, 32'h00);
        wr(acc_pkg::ACC_CSR_OFS, 8'h10);
        // Result follows the raw level
        cmp_raw_i <= 1'b1;
        tick(3);
        rchk(acc_pkg::ACC_CSR_OFS, 32'h20, 32'h20);
        cmp_raw_i <= 1'b0;
        tick(3);
        rchk(acc_pkg::ACC_CSR_OFS, 32'h20, 32'h0);
        // Each mode against a rise and a fall; reserved is only set
        for (int m = 0; m < 4; m++)
        begin
            wr(acc_pkg::ACC_CSR_OFS, 8'h10 | 8'(m));
            cmp_raw_i <= 1'b1;
            tick(4);
            if (m != 1)
                rchk(acc_pkg::ACC_CSR_OFS, 32'h10,
                     (m == 0 || m == 3) ? 32'h10 : 32'h0);
            wr(acc_pkg::ACC_CSR_OFS, 8'h10 | 8'(m));
            cmp_raw_i <= 1'b0;
            tick(4);
            if (m != 1)
                rchk(acc_pkg::ACC_CSR_OFS, 32'h10,
                     (m == 0 || m == 2) ? 32'h10 : 32'h0);
        end
        // Flag clearing and request gating, toggle mode
        wr(acc_pkg::ACC_CSR_OFS, 8'h10);
        cmp_raw_i <= 1'b1;
        tick(4);
        wr(acc_pkg::ACC_CSR_OFS, 8'h00);
        rchk(acc_pkg::ACC_CSR_OFS, 32'h10, 32'h10);
        chk({31'h0, cmp_irq_o}, 32'h0);
        wr(acc_pkg::ACC_CSR_OFS, 8'h08);
        tick(2);
        chk({31'h0, cmp_irq_o}, 32'h0);
        wr(acc_pkg::ACC_CFG_OFS, 8'h08);
        tick(2);
        chk({31'h0, cmp_irq_o}, 32'h1);
        vector_ack_i <= 1'b1;
        tick(1);
        vector_ack_i <= 1'b0;
        tick(2);
        chk({31'h0, cmp_irq_o}, 32'h0);
        rchk(acc_pkg::ACC_CSR_OFS, 32'h10, 32'h0);
        cmp_raw_i <= 1'b0;
        tick(4);
        chk({31'h0, cmp_irq_o}, 32'h1);
        wr(acc_pkg::ACC_CSR_OFS, 8'h18);
        tick(2);
        chk({31'h0, cmp_irq_o}, 32'h0);
        // Sticky status, mask and clear
        wr(acc_pkg::ACC_CSR_OFS, 8'h00);
        wr(acc_pkg::ACC_ISR_OFS, 8'h03);
        wr(acc_pkg::ACC_IMR_OFS, 8'h00);
        cmp_raw_i <= 1'b1;
        tick(4);
        rchk(acc_pkg::ACC_ISR_OFS, 32'h3, 32'h3);
        chk({31'h0, ev_irq_o}, 32'h0);
        wr(acc_pkg::ACC_IMR_OFS, 8'h02);
        tick(2);
        chk({31'h0, ev_irq_o}, 32'h1);
        wr(acc_pkg::ACC_ISR_OFS, 8'h02);
        tick(2);
        chk({31'h0, ev_irq_o}, 32'h0);
        rchk(acc_pkg::ACC_ISR_OFS, 32'h3, 32'h1);
        // Capture routing
        wr(acc_pkg::ACC_CSR_OFS, 8'h04);
        tick(2);
        chk({31'h0, capture_o}, 32'h1);
        cmp_raw_i <= 1'b0;
        tick(4);
        chk({31'h0, capture_o}, 32'h0);
        cmp_raw_i <= 1'b1;
        wr(acc_pkg::ACC_CSR_OFS, 8'h00);
        tick(4);
        chk({31'h0, capture_o}, 32'h0);
        // Pin buffers and pin reads
        cmp_pos_pin_i <= 1'b1;
        cmp_neg_pin_i <= 1'b1;
        tick(4);
        rchk(acc_pkg::ACC_PIN_OFS, 32'h3, 32'h3);
        wr(acc_pkg::ACC_DID_OFS, 8'h03);
        tick(2);
        chk({30'h0, pos_buf_en_o, neg_buf_en_o}, 32'h0);
        rchk(acc_pkg::ACC_PIN_OFS, 32'h3, 32'h0);
        wr(acc_pkg::ACC_DID_OFS, 8'h01);
        tick(3);
        rchk(acc_pkg::ACC_PIN_OFS, 32'h3, 32'h2);
        finish_test();
    end
endmodule
